// file: afm_pkg.sv
package afm_pkg;
	localparam int AFM_POS_W = 32;
	localparam int AFM_ERR_W = 32;
	localparam logic AFM_FAULT_RST = 1'b0;
	localparam logic AFM_STATUS_RST = 1'b0;
	localparam int AFM_UPDATE_CYCLES = 1;
	localparam int AFM_CH_A = 0;
	localparam int AFM_CH_B = 1;
	localparam int AFM_CH_Z = 2;
	localparam int AFM_CH_N = 3;
endpackage : afm_pkg

// file: afm_encoder_check.sv
`timescale 1ns/1ps
// one feedback source: wire loss and simultaneous a/b edges
module afm_encoder_check
	import afm_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// sample strobe and clear
	input wire logic update,
	input wire logic clear,
	// differential pairs
	input wire logic [AFM_CH_N-1:0] line_p,
	input wire logic [AFM_CH_N-1:0] line_n,
	input wire logic power_ok,
	// latched faults
	output logic loss_fault,
	output logic glitch_fault
);
	typedef struct packed {
		logic [1:0] last_ab;
		logic primed;
		logic loss;
		logic glitch;
	} afm_enc_state_t;

	afm_enc_state_t st;
	afm_enc_state_t next_st;
	logic loss_now;
	logic glitch_now;

	always_comb begin
		// a pair at equal level means a broken wire
		loss_now = (|(~(line_p ^ line_n))) | ~power_ok;
		// both channels changed in one sample: quadrature lost
		glitch_now = st.primed && (line_p[AFM_CH_A] != st.last_ab[0]) && (line_p[AFM_CH_B] != st.last_ab[1]);
		next_st = st;
		if (update) begin
			next_st.last_ab = {line_p[AFM_CH_B], line_p[AFM_CH_A]};
			next_st.primed = 1'b1;
		end
		// set wins over clear so an event in the clear cycle is kept
		next_st.loss = (st.loss & ~clear) | (update & loss_now);
		next_st.glitch = (st.glitch & ~clear) | (update & glitch_now);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign loss_fault = st.loss;
	assign glitch_fault = st.glitch;
endmodule : afm_encoder_check

// file: afm_axis_fault_status_monitor.sv
`timescale 1ns/1ps
module afm_axis_fault_status_monitor
	import afm_pkg::*;
#(
	parameter int POS_W = AFM_POS_W,
	parameter int ERR_W = AFM_ERR_W
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// servo loop timing and commands
	input wire logic servo_update,
	input wire logic fault_clear_command,
	input wire logic shutdown_clear_command,
	// limit switches
	input wire logic pos_limit_input,
	input wire logic neg_limit_input,
	// position and configuration
	input wire logic signed [POS_W-1:0] axis_position,
	input wire logic signed [POS_W-1:0] move_target,
	input wire logic move_active,
	input wire logic signed [POS_W-1:0] max_pos_travel,
	input wire logic signed [POS_W-1:0] max_neg_travel,
	input wire logic signed [ERR_W-1:0] position_error,
	input wire logic [ERR_W-1:0] position_error_tolerance,
	// primary feedback
	input wire logic [AFM_CH_N-1:0] primary_line_p,
	input wire logic [AFM_CH_N-1:0] primary_line_n,
	input wire logic primary_power_ok,
	// secondary feedback
	input wire logic [AFM_CH_N-1:0] secondary_line_p,
	input wire logic [AFM_CH_N-1:0] secondary_line_n,
	input wire logic secondary_power_ok,
	// status
	output logic pos_limit_input_state,
	output logic neg_limit_input_state,
	output logic pos_soft_travel_fault,
	output logic neg_soft_travel_fault,
	output logic pos_limit_switch_fault,
	output logic neg_limit_switch_fault,
	output logic primary_encoder_loss_fault,
	output logic primary_encoder_glitch_fault,
	output logic secondary_encoder_loss_fault,
	output logic secondary_encoder_glitch_fault,
	output logic following_error_fault
);
	// number of feedback sources, each watched by its own checker instance
	localparam int SRC_N = 2;
	localparam int SRC_PRIMARY = 0;
	localparam int SRC_SECONDARY = 1;

	typedef struct packed {
		logic pos_in;
		logic neg_in;
		logic pos_soft;
		logic neg_soft;
		logic pos_hard;
		logic neg_hard;
		logic follow;
	} afm_state_t;

	localparam afm_state_t AFM_ST_RST = '{
		pos_in: AFM_STATUS_RST,
		neg_in: AFM_STATUS_RST,
		pos_soft: AFM_FAULT_RST,
		neg_soft: AFM_FAULT_RST,
		pos_hard: AFM_FAULT_RST,
		neg_hard: AFM_FAULT_RST,
		follow: AFM_FAULT_RST
	};

	afm_state_t st;
	afm_state_t next_st;
	logic clear;
	logic [ERR_W-1:0] err_mag;
	logic err_over;

	// soft limit conditions, actual and attempted
	logic pos_at_over;
	logic pos_move_over;
	logic neg_at_over;
	logic neg_move_over;
	logic pos_soft_now;
	logic neg_soft_now;

	// latched fault conditions seen at this update
	logic pos_hard_now;
	logic neg_hard_now;
	logic follow_now;

	// per-source feedback wiring for the generate loop
	logic [AFM_CH_N-1:0] src_line_p [SRC_N];
	logic [AFM_CH_N-1:0] src_line_n [SRC_N];
	logic src_power_ok [SRC_N];
	logic src_loss [SRC_N];
	logic src_glitch [SRC_N];

	function automatic logic [ERR_W-1:0] afm_abs(
		input logic signed [ERR_W-1:0] v
	);
		afm_abs = v[ERR_W-1] ? ERR_W'(-v) : ERR_W'(v);
	endfunction : afm_abs

	// strict compares: sitting exactly on a limit is still inside it
	function automatic logic afm_above(
		input logic signed [POS_W-1:0] v,
		input logic signed [POS_W-1:0] lim
	);
		afm_above = v > lim;
	endfunction : afm_above

	function automatic logic afm_below(
		input logic signed [POS_W-1:0] v,
		input logic signed [POS_W-1:0] lim
	);
		afm_below = v < lim;
	endfunction : afm_below

	// set wins over clear so an event in the clear cycle is kept
	function automatic logic afm_latch(
		input logic held,
		input logic clr_now,
		input logic set_now
	);
		afm_latch = (held & ~clr_now) | set_now;
	endfunction : afm_latch

	assign clear = fault_clear_command | shutdown_clear_command;
	assign err_mag = afm_abs(position_error);
	assign err_over = err_mag > position_error_tolerance;

	// attempted moves count as well as actual position
	assign pos_at_over = afm_above(axis_position, max_pos_travel);
	assign pos_move_over = move_active & afm_above(move_target, max_pos_travel);
	assign neg_at_over = afm_below(axis_position, max_neg_travel);
	assign neg_move_over = move_active & afm_below(move_target, max_neg_travel);
	assign pos_soft_now = pos_at_over | pos_move_over;
	assign neg_soft_now = neg_at_over | neg_move_over;

	// an active switch re-latches at every update until it is released
	assign pos_hard_now = servo_update & pos_limit_input;
	assign neg_hard_now = servo_update & neg_limit_input;
	assign follow_now = servo_update & err_over;

	always_comb begin
		next_st = st;
		// inputs mirrored every clock so status never lags a servo period
		next_st.pos_in = pos_limit_input;
		next_st.neg_in = neg_limit_input;
		// soft faults hold between updates and clear themselves when back in range
		if (servo_update) begin
			next_st.pos_soft = pos_soft_now;
			next_st.neg_soft = neg_soft_now;
		end
		next_st.pos_hard = afm_latch(st.pos_hard, clear, pos_hard_now);
		next_st.neg_hard = afm_latch(st.neg_hard, clear, neg_hard_now);
		next_st.follow = afm_latch(st.follow, clear, follow_now);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= AFM_ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// each source gets its own checker instance; index 0 is the primary feedback
	assign src_line_p[SRC_PRIMARY] = primary_line_p;
	assign src_line_n[SRC_PRIMARY] = primary_line_n;
	assign src_power_ok[SRC_PRIMARY] = primary_power_ok;
	assign src_line_p[SRC_SECONDARY] = secondary_line_p;
	assign src_line_n[SRC_SECONDARY] = secondary_line_n;
	assign src_power_ok[SRC_SECONDARY] = secondary_power_ok;

	// a further source costs only another loop pass
	for (genvar s = 0; s < SRC_N; s++) begin : g_src
		afm_encoder_check u_check (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.update(servo_update),
			.clear(clear),
			.line_p(src_line_p[s]),
			.line_n(src_line_n[s]),
			.power_ok(src_power_ok[s]),
			.loss_fault(src_loss[s]),
			.glitch_fault(src_glitch[s])
		);
	end

	// sub-block outputs are its own flip-flops, so these stay registered
	assign primary_encoder_loss_fault = src_loss[SRC_PRIMARY];
	assign primary_encoder_glitch_fault = src_glitch[SRC_PRIMARY];
	assign secondary_encoder_loss_fault = src_loss[SRC_SECONDARY];
	assign secondary_encoder_glitch_fault = src_glitch[SRC_SECONDARY];

	// limit input status
	assign pos_limit_input_state = st.pos_in;
	assign neg_limit_input_state = st.neg_in;

	// soft travel faults
	assign pos_soft_travel_fault = st.pos_soft;
	assign neg_soft_travel_fault = st.neg_soft;

	// latched faults
	assign pos_limit_switch_fault = st.pos_hard;
	assign neg_limit_switch_fault = st.neg_hard;
	assign following_error_fault = st.follow;
endmodule : afm_axis_fault_status_monitor

// file: afm_monitor_chk.sv
`timescale 1ns/1ps
module afm_monitor_chk (
	input wire logic clk_sys, sys_rst, servo_update, fault_clear_command, shutdown_clear_command,
	input wire logic pos_limit_input, neg_limit_input, pos_limit_input_state, neg_limit_input_state,
	input wire logic pos_limit_switch_fault, neg_limit_switch_fault, pos_soft_travel_fault
);
	wire c = fault_clear_command | shutdown_clear_command;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	chk_neg_state: assert property (!$past(sys_rst) |-> neg_limit_input_state == $past(neg_limit_input))
		else $error("neg state");
	chk_pos_state: assert property (!$past(sys_rst) |-> pos_limit_input_state == $past(pos_limit_input))
		else $error("pos state");
	chk_pos_hard: assert property (servo_update && pos_limit_input |=> pos_limit_switch_fault) else $error("pos");
	chk_neg_hard: assert property (servo_update && neg_limit_input |=> neg_limit_switch_fault) else $error("neg");
	chk_fault_hold: assert property (!c |=> pos_limit_switch_fault >= $past(pos_limit_switch_fault))
		else $error("hold");
	chk_fault_clear: assert property (c && !servo_update |=> !neg_limit_switch_fault) else $error("clear");
	chk_soft_hold: assert property (!servo_update |=> $stable(pos_soft_travel_fault)) else $error("soft");
	chk_reset_zero: assert property ($fell(sys_rst) |-> !pos_limit_switch_fault) else $error("reset");
	cover property (c && neg_limit_switch_fault);
	cover property (servo_update && pos_limit_input);
	cover property (!servo_update && pos_soft_travel_fault);
endmodule : afm_monitor_chk
bind afm_axis_fault_status_monitor afm_monitor_chk afm_monitor_chk_inst (.*);

// file: afm_encoder_model.sv
`timescale 1ns/1ps
module afm_encoder_model (
	input wire logic clk_sys, step, jump,
	input wire logic [1:0] cut,
	output logic [2:0] line_p, line_n,
	output logic power_ok
);
	// jump moves both a and b at once, which a sound encoder never does
	logic [1:0] q = 2'h0;
	always @(posedge clk_sys) q <= q + {jump, step};
	assign line_p = {q == 2'h0, ^q, q[1]};
	assign line_n = ~line_p ^ {2'h0, cut[0]};
	assign power_ok = !cut[1];
endmodule : afm_encoder_model

// file: tb_afm_axis_fault_status_monitor.sv
`timescale 1ns/1ps
module tb_afm_axis_fault_status_monitor;
	logic clk_sys, sys_rst, servo_update, fault_clear_command, shutdown_clear_command, pos_limit_input;
	logic neg_limit_input, move_active, step;
	logic signed [31:0] axis_position, move_target, max_pos_travel, max_neg_travel, position_error;
	logic [31:0] position_error_tolerance;
	logic [1:0] jmp;
	logic [3:0] cut;
	wire [2:0] primary_line_p, primary_line_n, secondary_line_p, secondary_line_n;
	wire primary_power_ok, secondary_power_ok;
	wire [10:0] o;
	logic [10:0] exp_q [$];
	int fails, samples_checked, cycles;
	afm_axis_fault_status_monitor afm_axis_fault_status_monitor_inst (.*, .pos_limit_input_state(o[10]),
		.neg_limit_input_state(o[9]), .pos_soft_travel_fault(o[8]), .neg_soft_travel_fault(o[7]),
		.pos_limit_switch_fault(o[6]), .neg_limit_switch_fault(o[5]), .primary_encoder_loss_fault(o[4]),
		.primary_encoder_glitch_fault(o[3]), .secondary_encoder_loss_fault(o[2]),
		.secondary_encoder_glitch_fault(o[1]), .following_error_fault(o[0]));
	afm_encoder_model afm_encoder_model_inst [1:0] (.clk_sys, .step, .jump(jmp), .cut,
		.line_p({secondary_line_p, primary_line_p}), .line_n({secondary_line_n, primary_line_n}),
		.power_ok({secondary_power_ok, primary_power_ok}));
	task report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task check(input logic [10:0] seen, input logic [10:0] want);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task cyc(input logic [10:0] e);
		@(posedge clk_sys);
		#1 exp_q.push_back(e);
		step = 1'($urandom);
	endtask : cyc
	// no update while clearing, so no set condition can win over the clear
	task clr;
		{fault_clear_command, shutdown_clear_command, servo_update, step} = {2'($urandom_range(1, 3)), 2'h0};
		cyc(11'h000);
		{fault_clear_command, shutdown_clear_command, servo_update} = 3'h1;
	endtask : clr
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 200) begin
			fails++;
			report_and_stop();
		end
	end
	always @(negedge clk_sys) if (exp_q.size() > 0) check(o, exp_q.pop_front());
	initial begin
		void'($urandom(32'h1B7E));
		{sys_rst, servo_update, fault_clear_command, shutdown_clear_command, pos_limit_input} = 5'h18;
		{neg_limit_input, move_active, step, jmp, cut} = 9'h000;
		{axis_position, move_target, position_error} = 96'h0;
		{max_pos_travel, max_neg_travel, position_error_tolerance} = {32'sh64, -32'sh64, 32'h32};
		repeat (4) @(posedge clk_sys);
		#1 sys_rst = 1'h0;
		cyc(11'h000);
		pos_limit_input = 1'h1;
		cyc(11'h440);
		pos_limit_input = 1'h0;
		cyc(11'h040);
		clr();
		neg_limit_input = 1'h1;
		cyc(11'h220);
		neg_limit_input = 1'h0;
		cyc(11'h020);
		{neg_limit_input, fault_clear_command} = 2'h3;
		cyc(11'h220);
		neg_limit_input = 1'h0;
		clr();
		axis_position = 32'sh65 + 32'($urandom_range(999));
		cyc(11'h100);
		axis_position = 32'sh64;
		cyc(11'h000);
		axis_position = -32'sh65;
		cyc(11'h080);
		{axis_position, move_target, move_active} = {32'sh0, 32'sh65, 1'h1};
		cyc(11'h100);
		{servo_update, move_active, step} = 3'h0;
		cyc(11'h100);
		servo_update = 1'h1;
		cyc(11'h000);
		for (int i = 0; i < 2; i++) begin
			position_error = i ? -32'sh33 : 32'sh33 + 32'($urandom_range(99));
			cyc(11'h001);
			position_error = 32'sh32;
			cyc(11'h001);
			clr();
		end
		for (int i = 0; i < 4; i++) begin
			cut[i] = 1'h1;
			cyc(11'h010 >> (i & 2));
			cut = 4'h0;
			cyc(11'h010 >> (i & 2));
			clr();
		end
		for (int i = 0; i < 2; i++) begin
			{jmp[i], step} = 2'h2;
			cyc(11'h000);
			jmp = 2'h0;
			cyc(11'h008 >> (2 * i));
			clr();
		end
		@(posedge clk_sys);
		report_and_stop();
	end
endmodule : tb_afm_axis_fault_status_monitor
